// ### quad_switch_pkg.sv
// Purpose: Shared constants, types and field layouts for the quad switch mode and fail-safe control.
// Assumes: 200 MHz reference clock; serial words are 16 bits, watchdog bit first.
// Notes: Word layout, addresses and watchdog multiples are fixed here and used by every design file except level_sync.
// Function
// - Serial output driven only while select low
// - Output shifts on rising, host samples falling
// - Sixteen bit words, most significant bit first
// - Wake and reset low: sleep, outputs off
// - Start in sleep; settings read as zero
// - Reset high, no fault: normal, flag high
// - Wake or reset rising arms the watchdog
// - Watchdog expiry enters fail-safe until reinitialised
// - Fail-safe outputs follow the select pattern
// - Fail-safe pattern overrides inputs and combining
// - Grounded select disables watchdog and fail-safe
// - Fail-safe entry restores overcurrent and latch fields
// - Watchdog register bit two shows fail-safe
// - Leave fail-safe: both pins fall, select grounded
// - Logic supply loss resets settings and fault flags
// - Without supply, direct inputs still drive outputs
// - Any fault pulls the fault pin low
// - Fault pin releases itself unless fault latched
// - Latched fault released by new switch-on
// - Fault flags shifted out, cleared by transfer
// - Faulted outputs stay off in fault mode, except open-load channels
// - Received word committed on select rising
// - Status loaded into shifter on select falling
// - Serial input sampled on falling clock edge
// - Clock and input ignored while select high
package quad_switch_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  localparam int WD_UNIT_US = 1000;
  localparam int WD_UNIT_CYCLES = (WD_UNIT_US * 1000000) / CLK_PERIOD_PS;
  localparam int WD_PRESCALE_W = 20;
  localparam logic [6:0] WD_MULT_1 = 7'h10;
  localparam logic [6:0] WD_MULT_2 = 7'h20;
  localparam logic [6:0] WD_MULT_3 = 7'h40;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam logic [3:0] LAST_BIT_IDX = 4'hF;
  localparam logic [4:0] LAST_RX_CNT = 5'h0F;
  localparam logic [4:0] FULL_RX_CNT = 5'h10;
  localparam int WD_BIT_POS = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 12;
  localparam logic [2:0] ADDR_OUT_CTRL = 3'h0;
  localparam logic [2:0] ADDR_PROT = 3'h1;
  localparam logic [2:0] ADDR_WD = 3'h2;
  localparam logic [2:0] ADDR_READ_SEL = 3'h3;
  localparam int WATCHDOG_TIMEOUT_FLAG_POS = 2;

  // ----------------------------------------------------------------
  // Read selections, select resistor codes, combining modes
  // ----------------------------------------------------------------
  localparam logic [1:0] RD_FAULTS = 2'h0;
  localparam logic [1:0] RD_CONFIG = 2'h1;
  localparam logic [1:0] RD_WD = 2'h2;
  localparam logic [1:0] FSI_DISABLED = 2'h0;
  localparam logic [1:0] FSI_ALL_OFF = 2'h1;
  localparam logic [1:0] FSI_OUT0 = 2'h2;
  localparam logic [1:0] FSI_OUT02 = 2'h3;
  localparam logic [3:0] FS_PAT_OFF = 4'h0;
  localparam logic [3:0] FS_PAT_OUT0 = 4'h1;
  localparam logic [3:0] FS_PAT_OUT02 = 4'h5;
  localparam logic [1:0] COMB_DIRECT = 2'h0;
  localparam logic [1:0] COMB_OR = 2'h1;
  localparam logic [1:0] COMB_AND = 2'h2;
  localparam logic [1:0] COMB_SERIAL = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MODE_SLEEP = 4'h1,
    MODE_NORMAL = 4'h2,
    MODE_FAULT = 4'h4,
    MODE_FAILSAFE = 4'h8
  } mode_e;

  typedef struct packed {
    logic [3:0] overtemp;
    logic [3:0] overcurrent;
    logic [3:0] open_load;
    logic overvoltage;
    logic undervoltage;
  } fault_cond_s;

  typedef struct packed {
    logic [3:0] out_cmd;
    logic [1:0] combine;
    logic [2:0] overcurrent_low_level;
    logic overcurrent_high_level;
    logic [1:0] overcurrent_timing;
    logic [3:0] overtemp_unlatch_bits;
    logic [1:0] watchdog_period_setting;
    logic [1:0] read_sel;
  } cfg_s;

  localparam cfg_s CFG_RESET = '0;
  localparam fault_cond_s FAULT_NONE = '0;

endpackage

// ### level_sync.sv
// Purpose: Two-flop synchroniser for a vector of slow levels.
// Assumes: Each bit is an independent level; no bus coherency across bits.
// Notes: The first stage is read only by the second stage.
`timescale 1ns/1ps
module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // Two stages into the clock domain
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule // level_sync

// ### serial_link_shifter.sv
// Purpose: Serial-clock side shifter: shifts status out and collects one command word.
// Assumes: Serial clock stands low while select changes; tx_word_i is stable for the whole frame.
// Notes: Counters are held clear by select high, so stray clock edges between frames do nothing.
`timescale 1ns/1ps
module serial_link_shifter
  import quad_switch_pkg::*;
(
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic [WORD_W-1:0] tx_word_i,
  output logic so_o,
  output logic [WORD_W-1:0] rx_word_o,
  output logic rx_done_tgl_o
);

  logic [3:0] tx_cnt_r;
  logic [4:0] rx_cnt_r;
  logic [WORD_W-2:0] rx_sr_r;

  // ----------------------------------------------------------------
  // Transmit on rising edges, first edge presents bit 15
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (rst_i || cs_n_i) begin
      tx_cnt_r <= '0;
      so_o <= 1'b0;
    end else begin
      so_o <= tx_word_i[LAST_BIT_IDX - tx_cnt_r];
      tx_cnt_r <= 4'(tx_cnt_r + 4'h1);
    end
  end

  // ----------------------------------------------------------------
  // Receive on falling edges, count saturates after the word
  // ----------------------------------------------------------------
  always_ff @(negedge sclk_i or posedge cs_n_i or posedge rst_i) begin
    if (rst_i || cs_n_i) begin
      rx_cnt_r <= '0;
      rx_sr_r <= '0;
    end else begin
      rx_sr_r <= {rx_sr_r[WORD_W-3:0], si_i};
      if (rx_cnt_r != FULL_RX_CNT) begin
        rx_cnt_r <= 5'(rx_cnt_r + 5'h01);
      end
    end
  end

  // Sixteenth bit completes the word and flips the handoff toggle
  always_ff @(negedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_word_o <= '0;
      rx_done_tgl_o <= 1'b0;
    end else if (!cs_n_i && rx_cnt_r == LAST_RX_CNT) begin
      rx_word_o <= {rx_sr_r, si_i};
      rx_done_tgl_o <= ~rx_done_tgl_o;
    end
  end

endmodule // serial_link_shifter

// ### quad_switch_mode_failsafe_ctrl.sv
// Purpose: Mode, watchdog, fail-safe, fault reporting and serial framing for a quad high-side switch.
// Assumes: Pins and fault detector levels are asynchronous; serial clock comes from the host.
// Notes: Protection detectors are external; this block only latches, reports and gates outputs.
`timescale 1ns/1ps
module quad_switch_mode_failsafe_ctrl
  import quad_switch_pkg::*;
#(
  parameter int WD_UNIT_CYCLES_P = WD_UNIT_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic wake_i,
  input wire logic reset_pin_n_i,
  input wire logic [1:0] failsafe_select_in_i,
  input wire logic logic_supply_lost_i,
  input wire logic [3:0] direct_inputs_i,
  input wire fault_cond_s fault_cond_i,
  output logic [3:0] power_out_o,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe_o,
  output mode_e mode_o,
  output logic watchdog_timeout_flag_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (WD_UNIT_CYCLES_P < 1 || WD_UNIT_CYCLES_P >= (1 << WD_PRESCALE_W)) begin : g_bad_unit
    $error("WD_UNIT_CYCLES_P out of prescaler range");
  end

  localparam int PIN_W = 24;
  localparam logic [PIN_W-1:0] PIN_RST = {1'b1, {(PIN_W-1){1'b0}}};
  localparam logic [WD_PRESCALE_W-1:0] UNIT_LAST = WD_PRESCALE_W'(WD_UNIT_CYCLES_P - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_s;
  logic cs_high_s;
  logic wake_s;
  logic rstp_s;
  logic [1:0] fsi_s;
  logic lost_s;
  logic [3:0] din_s;
  fault_cond_s fc_s;
  logic wake_q_r;
  logic rstp_q_r;
  logic cs_high_q_r;
  logic wake_rise;
  logic rstp_rise;
  logic both_fall;
  logic sleep_s;
  logic fsi_dis;
  logic cs_fall;
  logic [WORD_W-1:0] rx_word;
  logic rx_tgl;
  logic rx_tgl_s;
  logic rx_tgl_q_r;
  logic pending_r;
  logic commit;
  logic [2:0] addr;
  logic wd_kick;
  cfg_s cfg_r;
  logic wd_armed_r;
  logic wd_last_r;
  logic [WD_PRESCALE_W-1:0] prescale_r;
  logic [6:0] unit_cnt_r;
  logic [6:0] wd_limit;
  logic wd_run;
  logic wd_expire;
  logic failsafe_r;
  logic fs_enter;
  logic [3:0] fs_pattern;
  logic [3:0] req;
  logic [3:0] req_q_r;
  logic [3:0] sw_on;
  logic [3:0] latch_set;
  logic [3:0] latch_r;
  logic [3:0] chan_off;
  logic fault_active;
  fault_cond_s flags_r;
  logic [1:0] tx_sel_r;
  logic [WORD_W-1:0] tx_word_r;
  logic [WORD_W-1:0] status_word;

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  level_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_pin_sync (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({cs_n_i, wake_i, reset_pin_n_i, failsafe_select_in_i, logic_supply_lost_i, direct_inputs_i,
          fault_cond_i}),
    .q_o(pins_s)
  );

  // Unpack the synchronised pin vector
  assign {cs_high_s, wake_s, rstp_s, fsi_s, lost_s, din_s, fc_s} = pins_s;

  // Previous values for edge detection
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_q_r <= 1'b0;
      rstp_q_r <= 1'b0;
      cs_high_q_r <= 1'b1;
    end else begin
      wake_q_r <= wake_s;
      rstp_q_r <= rstp_s;
      cs_high_q_r <= cs_high_s;
    end
  end

  // Pin events and decoded conditions
  assign wake_rise = wake_s & ~wake_q_r;
  assign rstp_rise = rstp_s & ~rstp_q_r;
  assign both_fall = wake_q_r & rstp_q_r & ~wake_s & ~rstp_s;
  assign sleep_s = ~wake_s & ~rstp_s;
  assign fsi_dis = (fsi_s == FSI_DISABLED);
  assign cs_fall = cs_high_q_r & ~cs_high_s;

  // ----------------------------------------------------------------
  // Serial link (serial clock domain)
  // ----------------------------------------------------------------
  serial_link_shifter u_link (
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .si_i(si_i),
    .tx_word_i(tx_word_r),
    .so_o(so_o),
    .rx_word_o(rx_word),
    .rx_done_tgl_o(rx_tgl)
  );

  // Output driver enabled only while select is low
  assign so_oe_o = ~cs_n_i;

  // Word-complete toggle crossing
  level_sync #(
    .W(1),
    .RST_VAL(1'b0)
  ) u_tgl_sync (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(rx_tgl),
    .q_o(rx_tgl_s)
  );

  // Hold a finished word until select returns high, then commit it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_tgl_q_r <= 1'b0;
      pending_r <= 1'b0;
    end else begin
      rx_tgl_q_r <= rx_tgl_s;
      if (rx_tgl_s ^ rx_tgl_q_r) begin
        pending_r <= 1'b1;
      end else if (commit) begin
        pending_r <= 1'b0;
      end
    end
  end

  assign commit = pending_r & cs_high_s;
  assign addr = rx_word[ADDR_MSB:ADDR_LSB];
  assign wd_kick = commit & (rx_word[WD_BIT_POS] != wd_last_r);

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RESET;
    end else if (lost_s || !rstp_s) begin
      cfg_r <= CFG_RESET;
    end else if (fs_enter) begin
      cfg_r.overcurrent_low_level <= CFG_RESET.overcurrent_low_level;
      cfg_r.overcurrent_high_level <= CFG_RESET.overcurrent_high_level;
      cfg_r.overcurrent_timing <= CFG_RESET.overcurrent_timing;
      cfg_r.overtemp_unlatch_bits <= CFG_RESET.overtemp_unlatch_bits;
    end else if (commit) begin
      unique case (addr)
        ADDR_OUT_CTRL: begin
          cfg_r.out_cmd <= rx_word[3:0];
          cfg_r.combine <= rx_word[5:4];
        end
        ADDR_PROT: begin
          cfg_r.overcurrent_low_level <= rx_word[2:0];
          cfg_r.overcurrent_high_level <= rx_word[3];
          cfg_r.overcurrent_timing <= rx_word[5:4];
          cfg_r.overtemp_unlatch_bits <= rx_word[9:6];
        end
        ADDR_WD: begin
          cfg_r.watchdog_period_setting <= rx_word[1:0];
        end
        ADDR_READ_SEL: begin
          cfg_r.read_sel <= rx_word[1:0];
        end
        default: begin
          cfg_r <= cfg_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // Arming on a rising wake or reset pin, never with select grounded
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_armed_r <= 1'b0;
    end else if (fsi_dis || sleep_s) begin
      wd_armed_r <= 1'b0;
    end else if (wake_rise || rstp_rise) begin
      wd_armed_r <= 1'b1;
    end
  end

  // Last seen watchdog bit
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_last_r <= 1'b0;
    end else if (commit) begin
      wd_last_r <= rx_word[WD_BIT_POS];
    end
  end

  // Period in units of the internal time base; setting zero disables
  always_comb begin
    unique case (cfg_r.watchdog_period_setting)
      2'h1: wd_limit = WD_MULT_1;
      2'h2: wd_limit = WD_MULT_2;
      2'h3: wd_limit = WD_MULT_3;
      default: wd_limit = WD_MULT_1;
    endcase
  end

  assign wd_run = wd_armed_r & (cfg_r.watchdog_period_setting != 2'h0) & ~failsafe_r;
  assign wd_expire = wd_run & (unit_cnt_r == wd_limit);

  // Time base prescaler and unit counter, restarted by each toggle
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prescale_r <= '0;
      unit_cnt_r <= '0;
    end else if (!wd_run || wd_kick) begin
      prescale_r <= '0;
      unit_cnt_r <= '0;
    end else if (prescale_r == UNIT_LAST) begin
      prescale_r <= '0;
      if (unit_cnt_r != wd_limit) begin
        unit_cnt_r <= 7'(unit_cnt_r + 7'h01);
      end
    end else begin
      prescale_r <= WD_PRESCALE_W'(prescale_r + 1'b1);
    end
  end

  // ----------------------------------------------------------------
  // Fail-safe state
  // ----------------------------------------------------------------
  assign fs_enter = wd_expire & ~fsi_dis;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      failsafe_r <= 1'b0;
    end else if (both_fall || fsi_dis) begin
      failsafe_r <= 1'b0;
    end else if (fs_enter) begin
      failsafe_r <= 1'b1;
    end
  end

  // Fail-safe output pattern from the select resistor code
  always_comb begin
    unique case (fsi_s)
      FSI_OUT0: fs_pattern = FS_PAT_OUT0;
      FSI_OUT02: fs_pattern = FS_PAT_OUT02;
      default: fs_pattern = FS_PAT_OFF;
    endcase
  end

  // ----------------------------------------------------------------
  // Output request
  // ----------------------------------------------------------------
  always_comb begin
    if (failsafe_r) begin
      req = fs_pattern;
    end else begin
      unique case (cfg_r.combine)
        COMB_OR: req = din_s | cfg_r.out_cmd;
        COMB_AND: req = din_s & cfg_r.out_cmd;
        COMB_SERIAL: req = cfg_r.out_cmd;
        default: req = din_s;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Fault latching and output gating
  // ----------------------------------------------------------------
  assign sw_on = req & ~req_q_r;
  assign latch_set = fc_s.overcurrent | (fc_s.overtemp & ~cfg_r.overtemp_unlatch_bits) |
                     ({4{fc_s.undervoltage}} & req);
  assign chan_off = latch_r | fc_s.overtemp | {4{fc_s.overvoltage | fc_s.undervoltage}};
  assign fault_active = (|latch_r) | (|fc_s.overtemp) | (|fc_s.overcurrent) | (|fc_s.open_load) |
                        fc_s.overvoltage | fc_s.undervoltage;

  // Per-channel latch; a fresh condition wins over a switch-on release
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      latch_r <= '0;
      req_q_r <= '0;
    end else begin
      req_q_r <= req;
      if (!rstp_s && !lost_s) begin
        latch_r <= '0;
      end else begin
        latch_r <= (latch_r & ~sw_on) | latch_set;
      end
    end
  end

  // Registered output stage
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_out_o <= '0;
    end else if (sleep_s && !lost_s) begin
      power_out_o <= '0;
    end else begin
      power_out_o <= req & ~chan_off;
    end
  end

  // Open-drain fault pin: drives low only while a fault stands
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_flag_n_oe_o <= 1'b0;
    end else begin
      fault_flag_n_oe_o <= fault_active;
    end
  end

  assign fault_flag_n_o = 1'b0;

  // Mode report
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_o <= MODE_SLEEP;
    end else if (sleep_s) begin
      mode_o <= MODE_SLEEP;
    end else if (failsafe_r) begin
      mode_o <= MODE_FAILSAFE;
    end else if (fault_active) begin
      mode_o <= MODE_FAULT;
    end else begin
      mode_o <= MODE_NORMAL;
    end
  end

  assign watchdog_timeout_flag_o = failsafe_r;

  // ----------------------------------------------------------------
  // Fault register
  // ----------------------------------------------------------------
  // Sticky flags; a standing condition survives the read clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_r <= FAULT_NONE;
    end else if (lost_s || !rstp_s) begin
      flags_r <= FAULT_NONE;
    end else if (commit && tx_sel_r == RD_FAULTS) begin
      flags_r <= fc_s;
    end else begin
      flags_r <= flags_r | fc_s;
    end
  end

  // ----------------------------------------------------------------
  // Status word, loaded when select falls
  // ----------------------------------------------------------------
  always_comb begin
    unique case (cfg_r.read_sel)
      RD_CONFIG: status_word = {cfg_r.out_cmd, cfg_r.combine, cfg_r.overcurrent_low_level,
                                cfg_r.overcurrent_high_level, cfg_r.overcurrent_timing,
                                cfg_r.overtemp_unlatch_bits};
      RD_WD: begin
        status_word = '0;
        status_word[7:4] = din_s;
        status_word[3] = wd_armed_r;
        status_word[WATCHDOG_TIMEOUT_FLAG_POS] = failsafe_r;
        status_word[1:0] = cfg_r.watchdog_period_setting;
      end
      default: status_word = {flags_r, 2'b00};
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_word_r <= '0;
      tx_sel_r <= RD_FAULTS;
    end else if (cs_fall) begin
      tx_word_r <= status_word;
      tx_sel_r <= cfg_r.read_sel;
    end
  end

endmodule // quad_switch_mode_failsafe_ctrl

// ### quad_switch_mode_failsafe_ctrl_asserts.sv
// Purpose: Port checks for the switch controller.
// Assumes: Pins reach the logic within six cycles.
// Notes: Bound to every controller instance.
`timescale 1ns/1ps
module quad_switch_mode_failsafe_ctrl_asserts
  import quad_switch_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic so_oe_o,
  input wire logic wake_i,
  input wire logic reset_pin_n_i,
  input wire logic [1:0] failsafe_select_in_i,
  input wire logic logic_supply_lost_i,
  input wire fault_cond_s fault_cond_i,
  input wire logic [3:0] power_out_o,
  input wire logic fault_flag_n_oe_o,
  input wire mode_e mode_o,
  input wire logic watchdog_timeout_flag_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Output pattern of each select code
  logic [3:0] pat;
  assign pat = failsafe_select_in_i == FSI_OUT02 ? FS_PAT_OUT02 : {3'h0, failsafe_select_in_i == FSI_OUT0};
  a_so_hiz: assert property (so_oe_o == !cs_n_i) else $error("so enable");
  a_sleep_off: assert property ((mode_o == MODE_SLEEP && !logic_supply_lost_i)[*6] |->
    power_out_o == 4'h0) else $error("sleep out");
  a_sleep_entry: assert property ((!wake_i && !reset_pin_n_i && !logic_supply_lost_i &&
    !watchdog_timeout_flag_o)[*6] |-> mode_o == MODE_SLEEP) else $error("sleep mode");
  a_fs_pattern: assert property ((mode_o == MODE_FAILSAFE && fault_cond_i == FAULT_NONE &&
    $stable(failsafe_select_in_i))[*6] ##0 !fault_flag_n_oe_o |-> power_out_o == pat) else $error("fs pattern");
  a_watchdog_timeout_flag_flag: assert property (mode_o == MODE_FAILSAFE |->
    $past(watchdog_timeout_flag_o)) else $error("watchdog_timeout_flag");
  a_fs_disabled: assert property ((failsafe_select_in_i == FSI_DISABLED)[*6] |->
    !watchdog_timeout_flag_o) else $error("fs disabled");
  a_fault_pin: assert property (reset_pin_n_i && $rose(|fault_cond_i) |->
    ##[1:6] fault_flag_n_oe_o) else $error("fault pin");
  a_ov_off: assert property (fault_cond_i.overvoltage[*6] |-> power_out_o == 4'h0) else $error("ov out");
  a_normal_pin: assert property ((mode_o == MODE_NORMAL)[*3] |-> !fault_flag_n_oe_o) else $error("normal");
  c_failsafe: cover property (mode_o == MODE_FAILSAFE);
  c_fault: cover property (fault_flag_n_oe_o);
  c_no_supply: cover property (mode_o == MODE_SLEEP && logic_supply_lost_i);
endmodule // quad_switch_mode_failsafe_ctrl_asserts
bind quad_switch_mode_failsafe_ctrl quad_switch_mode_failsafe_ctrl_asserts chk (.ref_clk_i, .rst_i, .cs_n_i,
  .so_oe_o, .wake_i, .reset_pin_n_i, .failsafe_select_in_i, .logic_supply_lost_i, .fault_cond_i, .power_out_o,
  .fault_flag_n_oe_o, .mode_o, .watchdog_timeout_flag_o);

// ### host_spi_model.sv
// Purpose: Host serial master framing 16-bit words.
// Assumes: Half period 6 ns, clock low between frames.
// Notes: Released data line reads inverted.
`timescale 1ns/1ps
module host_spi_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i,
  input wire logic so_oe_i
);
  logic seen;
  assign seen = so_oe_i ? so_i : ~so_i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end
  // One word each way, high bit first
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_o = 1'b0;
    #24;
    for (int i = 15; i >= 0; i--) begin
      si_o = tx[i];
      sclk_o = 1'b1;
      #6;
      sclk_o = 1'b0;
      rx[i] = seen;
      #6;
    end
    cs_n_o = 1'b1;
    si_o = 1'b0;
    #40;
  endtask
endmodule // host_spi_model

// ### test_quad_switch_mode_failsafe_ctrl.sv
// Purpose: Self-checking bench for the switch controller.
// Assumes: Pin changes settle within eight cycles.
// Notes: Watchdog unit cut to ten cycles.
`timescale 1ns/1ps
module test_quad_switch_mode_failsafe_ctrl;
  import quad_switch_pkg::*;
  logic ref_clk_i = 0, rst_i = 1, wake_i = 0, reset_pin_n_i = 0, logic_supply_lost_i = 0;
  logic [1:0] failsafe_select_in_i = 0;
  logic [3:0] direct_inputs_i = 0;
  fault_cond_s fault_cond_i = '0;
  logic sclk_i, cs_n_i, si_i, so_o, so_oe_o, fault_flag_n_o, fault_flag_n_oe_o, watchdog_timeout_flag_o;
  logic [3:0] power_out_o;
  mode_e mode_o;
  logic [15:0] rx;
  int error_cnt = 0, n_checks = 0, cycles = 0;
  wire fpin = fault_flag_n_oe_o ? fault_flag_n_o : 1'b1;
  always #2.5 ref_clk_i = ~ref_clk_i;
  quad_switch_mode_failsafe_ctrl #(.WD_UNIT_CYCLES_P(10)) uut (.ref_clk_i, .rst_i, .sclk_i, .cs_n_i, .si_i,
    .so_o, .so_oe_o, .wake_i, .reset_pin_n_i, .failsafe_select_in_i, .logic_supply_lost_i,
    .direct_inputs_i, .fault_cond_i, .power_out_o, .fault_flag_n_o, .fault_flag_n_oe_o, .mode_o,
    .watchdog_timeout_flag_o);
  host_spi_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_i(so_oe_o));
  task cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task pins(input logic [1:0] v);
    {wake_i, reset_pin_n_i} = v;
    cyc(8);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Cycle ceiling
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 12000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  task t_sleep;
    direct_inputs_i = 4'hF;
    cyc(8);
    chk("sleep mode", MODE_SLEEP, mode_o);
    chk("sleep out", 4'h0, power_out_o);
    logic_supply_lost_i = 1;
    cyc(8);
    chk("no supply", 4'hF, power_out_o);
    logic_supply_lost_i = 0;
    direct_inputs_i = 4'h0;
    $display("sleep done");
  endtask
  task t_failsafe;
    for (int c = 1; c < 4; c++) begin
      failsafe_select_in_i = c[1:0];
      pins(2'b00);
      pins(2'b11);
      host.xfer(16'h13FF, rx);
      host.xfer(16'h3001, rx);
      for (int k = 0; k < 5; k++) host.xfer({k[0], 15'h2001}, rx);
      chk("alive", MODE_NORMAL, mode_o);
      chk("config", 16'h03FF, rx);
      cyc(1);
      direct_inputs_i = 4'hA;
      cyc(200);
      chk("fs mode", MODE_FAILSAFE, mode_o);
      chk("fs out", c == 1 ? FS_PAT_OFF : c == 2 ? FS_PAT_OUT0 : FS_PAT_OUT02, power_out_o);
      host.xfer(16'h3002, rx);
      chk("fs config", 16'h0000, rx);
      host.xfer(16'h4000, rx);
      chk("wd word", 16'h00AD, rx);
      if (c == 2) begin
        failsafe_select_in_i = FSI_DISABLED;
        cyc(8);
        failsafe_select_in_i = 2'h2;
      end else begin
        pins(2'b00);
      end
      cyc(8);
      chk("fs exit", 16'h0, watchdog_timeout_flag_o);
    end
    failsafe_select_in_i = FSI_DISABLED;
    pins(2'b00);
    pins(2'b11);
    host.xfer(16'h2001, rx);
    cyc(250);
    chk("no watchdog", MODE_NORMAL, mode_o);
    chk("normal out", 4'hA, power_out_o);
    $display("failsafe done");
  endtask
  task t_fault;
    fault_cond_i.overvoltage = 1;
    cyc(8);
    chk("ov pin", 1'b0, fpin);
    chk("fault mode", MODE_FAULT, mode_o);
    fault_cond_i.overvoltage = 0;
    cyc(8);
    chk("ov clear", 1'b1, fpin);
    fault_cond_i.overcurrent = 4'h2;
    cyc(8);
    fault_cond_i.overcurrent = 4'h0;
    cyc(8);
    chk("oc latch", 1'b0, fpin);
    chk("oc off", 4'h8, power_out_o);
    direct_inputs_i = 4'h8;
    cyc(8);
    direct_inputs_i = 4'hA;
    cyc(8);
    chk("oc release", 1'b1, fpin);
    host.xfer(16'h4000, rx);
    chk("faults", 16'h0208, rx);
    host.xfer(16'h4000, rx);
    chk("cleared", 16'h0000, rx);
    host.xfer(16'h0011, rx);
    chk("or mode", 4'hB, power_out_o);
    host.xfer(16'h0023, rx);
    chk("and mode", 4'h2, power_out_o);
    host.xfer(16'h0034, rx);
    chk("serial mode", 4'h4, power_out_o);
    $display("fault done");
  endtask
  initial begin
    cyc(8);
    rst_i = 0;
    cyc(4);
    t_sleep();
    t_failsafe();
    t_fault();
    report_and_stop();
  end
endmodule // test_quad_switch_mode_failsafe_ctrl
